// ==== src/sce_defines.svh ====
// Constants for the two-wire command engine
`ifndef SCE_DEFINES_SVH
`define SCE_DEFINES_SVH
`define SCE_CMD_BLKW 8'ha5
`define SCE_CMD_BLKR 8'ha6
`define SCE_CMD_REBOOT 8'ha7
`define SCE_CMD_SAVE 8'ha8
`define SCE_CMD_FLASH_ON 8'ha9
`define SCE_CMD_FLASH_OFF 8'haa
`define SCE_CMD_USER_ON 8'hab
`define SCE_CMD_USER_OFF 8'hac
`define SCE_ARA_ADDR 7'h09
`define SCE_BLK_MAX 5'h10
`define SCE_BLK_MIN 8'h01
`define SCE_BLK_CNT 8'h10
`define SCE_LIM_CFG 8'h8f
`define SCE_LIM_USER 8'hff
`define SCE_ALERT_REG 8'h1c
`define SCE_ALERT_BIT 7
`define SCE_CRC_POLY 8'h07
`define SCE_CRC_INIT 8'h00
`define SCE_BIT_DATA 4'h7
`define SCE_BIT_ACK 4'h8
`define SCE_BIT_END 4'h9
`define SCE_BYTE_ADDR 5'h00
`define SCE_BYTE_CMD 5'h01
`define SCE_BYTE_D0 5'h02
`define SCE_BYTE_D1 5'h03
`define SCE_BYTE_SAT 5'h1f
`define SCE_IDLE_BYTE 8'hff
`define SCE_PTR_RST 8'h00
`endif

// ==== src/sce_pkg.sv ====
// Types shared by the two-wire command engine
package sce_pkg;
  typedef enum logic [1:0] {
    SCE_ST_IDLE = 2'b00,
    SCE_ST_RX = 2'b01,
    SCE_ST_TX = 2'b10,
    SCE_ST_WAIT = 2'b11
  } sce_state_t;
  typedef enum logic [1:0] {
    SCE_PG_DEF = 2'b00,
    SCE_PG_FLASH = 2'b01,
    SCE_PG_USER = 2'b10
  } sce_page_t;
  typedef enum logic [2:0] {
    SCE_P_NONE = 3'b000,
    SCE_P_WBYTE = 3'b001,
    SCE_P_BLKW = 3'b010,
    SCE_P_READ = 3'b011,
    SCE_P_BLKR = 3'b100
  } sce_proto_t;
  typedef struct packed {
    logic ptr_load;
    logic cmd;
    logic [7:0] val;
  } sce_pend_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
  } sce_mem_t;
endpackage : sce_pkg

// ==== src/sce_engine.sv ====
// Two-wire slave command engine sampled on the system clock
// Operation
// - Reboot code pulses reboot request, reloading configuration like power-on.
// - Emergency-save code pulses the fault store request.
// - A9h flash page, AAh default, ABh user from flash only, ACh back.
// - Send-byte data byte loads the memory pointer.
// - Block codes are acknowledged; disallowed address or code is not-acknowledged.
// - STOP before the pointer byte acknowledge leaves the pointer unchanged.
// - Receive byte returns byte at pointer, then pointer increments by one.
// - Invalid address at write or read byte is refused, no change, no write.
// - With checking on, trailing check byte acknowledged only when correct.
// - With checking on, read byte appends a check byte after master acknowledge.
// - Block write is decoded as A5h only.
// - Block write code refused while busy, pointer unchanged.
// - After block write the pointer sits at the next valid address.
// - Block pointer saturates at 8Fh config pages, FFh user page.
// - Block read code A6h acknowledged unless busy, then read after restart.
// - Block read returns count 16, then data, check byte when enabled.
// - Alert pin pulled low on fault when enabled and pin one is alert.
// - Alert response read is acknowledged, returns own address, releases alert.
// - Alert status bit cleared by writing one, only after alert response.
// - Pin one as alert with enable clear acts as fault output.
// - Bus refuses access while the JTAG port holds internal memory.
// - Check bytes only when the checking enable input is set.
// - Check byte is CRC-8, polynomial x^8+x^2+x+1, over all bytes.
// - Command byte refused during reboot or flash programming.
`timescale 1ns/1ps
`include "sce_defines.svh"
module sce_engine
  import sce_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic gp1_out,
  output logic gp1_oe,
  input wire logic [6:0] slave_addr,
  input wire logic pec_en,
  input wire logic alert_en,
  input wire logic gp1_alert,
  input wire logic fault,
  input wire logic dev_busy,
  input wire logic jtag_busy,
  input wire logic [7:0] mem_rdata,
  output sce_mem_t mem_o,
  output sce_page_t page_o,
  output logic reboot_req,
  output logic save_req,
  output logic alert_status,
  output logic smb_claim
);
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ `SCE_CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : crc8

  function automatic logic [7:0] sat_inc(input logic [7:0] p, input sce_page_t pg);
    logic [7:0] lim;
    lim = (pg == SCE_PG_USER) ? `SCE_LIM_USER : `SCE_LIM_CFG;
    return (p >= lim) ? lim : p + 8'h01;
  endfunction : sat_inc

  function automatic logic addr_ok(input logic [7:0] a, input sce_page_t pg);
    return (pg == SCE_PG_USER) || (a <= `SCE_LIM_CFG);
  endfunction : addr_ok

  // Pins cross from the master's domain through three flops each
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= 3'h7;
    end else begin
      {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= {scl_in, scl_s1_reg, scl_s2_reg};
      {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= {sda_in, sda_s1_reg, sda_s2_reg};
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s2_reg & ~scl_s3_reg;
  assign scl_fall = ~scl_s2_reg & scl_s3_reg;
  assign bus_start = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
  assign bus_stop = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

  sce_state_t st_reg, st_next;
  sce_page_t page_reg, page_next;
  sce_proto_t proto_reg, proto_next;
  sce_pend_t pend_reg, pend_next;
  sce_mem_t mem_reg, mem_next;
  logic [3:0] bit_reg, bit_next;
  logic [4:0] byte_reg, byte_next, cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next, crc_reg, crc_next;
  logic ack_reg, ack_next, rw_reg, rw_next, ara_reg, ara_next;
  logic drv_reg, drv_next, pec_reg, pec_next, blkr_reg, blkr_next;
  logic reboot_reg, reboot_next, save_reg, save_next, claim_reg, claim_next;
  logic apend_reg, apend_next, astat_reg, astat_next, fault_d_reg;
  logic gp1_oe_reg, gp1_oe_next, lo_reg;
  logic [7:0] rxb;
  logic load_data, alert_clr, alert_evt, is_cmd, own, ara;

  always_comb begin
    st_next = st_reg;
    page_next = page_reg;
    proto_next = proto_reg;
    pend_next = pend_reg;
    mem_next = '{addr: ptr_reg, wdata: mem_reg.wdata, we: 1'b0};
    bit_next = bit_reg;
    byte_next = byte_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    crc_next = crc_reg;
    ack_next = ack_reg;
    rw_next = rw_reg;
    ara_next = ara_reg;
    drv_next = drv_reg;
    pec_next = pec_reg;
    blkr_next = blkr_reg;
    claim_next = claim_reg;
    reboot_next = 1'b0;
    save_next = 1'b0;
    load_data = 1'b0;
    alert_clr = 1'b0;
    rxb = {shift_reg[6:0], sda_s2_reg};
    is_cmd = (rxb >= `SCE_CMD_BLKW) && (rxb <= `SCE_CMD_USER_OFF);
    own = (rxb[7:1] == slave_addr);
    ara = (rxb[7:1] == `SCE_ARA_ADDR) && rxb[0] && apend_reg;
    alert_evt = fault & ~fault_d_reg & gp1_alert & alert_en;
    apend_next = apend_reg;
    if (bus_start) begin
      if (st_reg == SCE_ST_IDLE) begin
        crc_next = `SCE_CRC_INIT;
      end
      st_next = SCE_ST_RX;
      bit_next = 4'h0;
      byte_next = `SCE_BYTE_ADDR;
      drv_next = 1'b0;
      pec_next = 1'b0;
    end else if (bus_stop) begin
      // Pending pointer load is dropped here
      st_next = SCE_ST_IDLE;
      drv_next = 1'b0;
      proto_next = SCE_P_NONE;
      blkr_next = 1'b0;
      claim_next = 1'b0;
      pend_next = '0;
    end else begin
      case (st_reg)
        SCE_ST_RX: begin
          if (scl_rise && bit_reg <= `SCE_BIT_DATA) begin
            bit_next = bit_reg + 4'h1;
            shift_next = rxb;
          end else if (scl_rise) begin
            bit_next = `SCE_BIT_END;
          end
          if (scl_rise && bit_reg == `SCE_BIT_DATA) begin
            byte_next = (byte_reg == `SCE_BYTE_SAT) ? byte_reg : byte_reg + 5'h01;
            crc_next = crc8(crc_reg, rxb);
            ack_next = 1'b0;
            pend_next = '0;
            if (byte_reg == `SCE_BYTE_ADDR) begin
              ack_next = (own & ~jtag_busy) | ara;
              rw_next = rxb[0];
              ara_next = ara;
              cnt_next = 5'h00;
              if ((own & ~jtag_busy) | ara) begin
                claim_next = own;
              end
              if (((own & ~jtag_busy) | ara) && rxb[0]) begin
                if (ara) begin
                  shift_next = {slave_addr, 1'b0};
                end else if (blkr_reg) begin
                  proto_next = SCE_P_BLKR;
                  blkr_next = 1'b0;
                  shift_next = `SCE_BLK_CNT;
                  crc_next = crc8(crc_next, `SCE_BLK_CNT);
                end else begin
                  proto_next = (proto_reg == SCE_P_WBYTE) ? SCE_P_READ : SCE_P_NONE;
                  load_data = 1'b1;
                end
              end
            end else if (byte_reg == `SCE_BYTE_CMD) begin
              pend_next = '{ptr_load: ~is_cmd, cmd: is_cmd, val: rxb};
              if (dev_busy) begin
                ack_next = 1'b0;
              end else if (!is_cmd) begin
                ack_next = addr_ok(rxb, page_reg);
              end else begin
                case (rxb)
                  `SCE_CMD_USER_ON: ack_next = (page_reg == SCE_PG_FLASH);
                  `SCE_CMD_USER_OFF: ack_next = (page_reg == SCE_PG_USER);
                  default: ack_next = 1'b1;
                endcase
              end
            end else if (proto_reg == SCE_P_BLKW) begin
              if (byte_reg == `SCE_BYTE_D0) begin
                ack_next = (rxb >= `SCE_BLK_MIN) && (rxb <= `SCE_BLK_CNT);
                cnt_next = rxb[4:0];
              end else if (cnt_reg != 5'h00) begin
                ack_next = 1'b1;
                mem_next = '{addr: ptr_reg, wdata: rxb, we: 1'b1};
                cnt_next = cnt_reg - 5'h01;
                ptr_next = sat_inc(ptr_reg, page_reg);
              end else if (pec_en && !pec_reg) begin
                ack_next = (crc_reg == rxb);
                pec_next = 1'b1;
              end
            end else if (proto_reg == SCE_P_WBYTE) begin
              if (byte_reg == `SCE_BYTE_D0) begin
                ack_next = 1'b1;
                mem_next = '{addr: ptr_reg, wdata: rxb, we: 1'b1};
                alert_clr = (page_reg == SCE_PG_DEF) && (ptr_reg == `SCE_ALERT_REG)
                  && rxb[`SCE_ALERT_BIT] && !apend_reg;
              end else if (byte_reg == `SCE_BYTE_D1 && pec_en) begin
                ack_next = (crc_reg == rxb);
              end
            end
          end
          if (scl_fall && bit_reg == `SCE_BIT_ACK) begin
            drv_next = ack_reg;
            if (ack_reg && pend_reg.ptr_load) begin
              ptr_next = pend_reg.val;
              proto_next = SCE_P_WBYTE;
            end
            if (ack_reg && pend_reg.cmd) begin
              case (pend_reg.val)
                `SCE_CMD_BLKW: proto_next = SCE_P_BLKW;
                `SCE_CMD_BLKR: blkr_next = 1'b1;
                `SCE_CMD_REBOOT: begin
                  reboot_next = 1'b1;
                  page_next = SCE_PG_DEF;
                end
                `SCE_CMD_SAVE: save_next = 1'b1;
                `SCE_CMD_FLASH_ON: page_next = SCE_PG_FLASH;
                `SCE_CMD_FLASH_OFF: page_next = SCE_PG_DEF;
                `SCE_CMD_USER_ON: page_next = SCE_PG_USER;
                default: page_next = SCE_PG_FLASH;
              endcase
            end
            pend_next = '0;
          end else if (scl_fall && bit_reg == `SCE_BIT_END) begin
            bit_next = 4'h0;
            if (!ack_reg) begin
              drv_next = 1'b0;
              st_next = SCE_ST_WAIT;
            end else if (rw_reg && byte_reg == `SCE_BYTE_CMD) begin
              st_next = SCE_ST_TX;
              drv_next = ~shift_reg[7];
            end else begin
              drv_next = 1'b0;
            end
          end
        end
        SCE_ST_TX: begin
          if (scl_rise && bit_reg < `SCE_BIT_ACK) begin
            bit_next = bit_reg + 4'h1;
            shift_next = {shift_reg[6:0], 1'b1};
          end else if (scl_rise) begin
            bit_next = 4'h0;
            if (ara_reg) begin
              apend_next = 1'b0;
            end
            // Master acknowledge asks for one more byte
            if (sda_s2_reg || ara_reg) begin
              st_next = SCE_ST_WAIT;
            end else if (proto_reg == SCE_P_BLKR && cnt_reg < `SCE_BLK_MAX) begin
              load_data = 1'b1;
              cnt_next = cnt_reg + 5'h01;
            end else if (proto_reg != SCE_P_NONE && pec_en && !pec_reg) begin
              shift_next = crc_reg;
              pec_next = 1'b1;
            end else if (proto_reg == SCE_P_NONE) begin
              load_data = 1'b1;
            end else begin
              shift_next = `SCE_IDLE_BYTE;
            end
          end
          if (scl_fall) begin
            drv_next = (bit_reg < `SCE_BIT_ACK) ? ~shift_reg[7] : 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (load_data) begin
      shift_next = mem_rdata;
      crc_next = crc8(crc_next, mem_rdata);
      // Block reads saturate, single reads step by one
      ptr_next = (proto_next == SCE_P_BLKR) ? sat_inc(ptr_reg, page_reg) : ptr_reg + 8'h01;
    end
    if (!mem_next.we) begin
      mem_next.addr = ptr_next;
    end
    if (alert_evt) begin
      apend_next = 1'b1;
    end
    astat_next = alert_evt | (astat_reg & ~alert_clr);
    // Open drain: pull low only, never drive high
    gp1_oe_next = gp1_alert & (alert_en ? apend_next : fault);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= SCE_ST_IDLE;
      page_reg <= SCE_PG_DEF;
      proto_reg <= SCE_P_NONE;
      pend_reg <= '0;
      mem_reg <= '0;
      bit_reg <= 4'h0;
      byte_reg <= `SCE_BYTE_ADDR;
      cnt_reg <= 5'h00;
      shift_reg <= `SCE_IDLE_BYTE;
      ptr_reg <= `SCE_PTR_RST;
      crc_reg <= `SCE_CRC_INIT;
      {ack_reg, rw_reg, ara_reg, drv_reg, pec_reg, blkr_reg} <= 6'h00;
      {reboot_reg, save_reg, claim_reg, apend_reg, astat_reg} <= 5'h00;
      {fault_d_reg, gp1_oe_reg, lo_reg} <= 3'h0;
    end else begin
      st_reg <= st_next;
      page_reg <= page_next;
      proto_reg <= proto_next;
      pend_reg <= pend_next;
      mem_reg <= mem_next;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      crc_reg <= crc_next;
      {ack_reg, rw_reg, ara_reg} <= {ack_next, rw_next, ara_next};
      {drv_reg, pec_reg, blkr_reg} <= {drv_next, pec_next, blkr_next};
      {reboot_reg, save_reg, claim_reg} <= {reboot_next, save_next, claim_next};
      {apend_reg, astat_reg} <= {apend_next, astat_next};
      {fault_d_reg, gp1_oe_reg, lo_reg} <= {fault, gp1_oe_next, 1'b0};
    end
  end

  assign sda_out = lo_reg;
  assign sda_oe = drv_reg;
  assign gp1_out = lo_reg;
  assign gp1_oe = gp1_oe_reg;
  assign mem_o = mem_reg;
  assign page_o = page_reg;
  assign reboot_req = reboot_reg;
  assign save_req = save_reg;
  assign alert_status = astat_reg;
  assign smb_claim = claim_reg;
endmodule : sce_engine

// ==== dv/sce_engine_assertions.sv ====
// Port-level property checks for the command engine
`timescale 1ns/1ps
module sce_engine_assertions
  import sce_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic alert_en,
  input wire logic gp1_alert,
  input wire logic fault,
  input wire logic jtag_busy,
  input wire logic sda_oe,
  input wire logic gp1_oe,
  input sce_mem_t mem_o,
  input sce_page_t page_o,
  input wire logic reboot_req,
  input wire logic save_req,
  input wire logic smb_claim
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_reboot_pulse: assert property (reboot_req |=> !reboot_req)
    else $error("reboot request held too long");
  a_reboot_page: assert property (reboot_req |-> ##[0:2] page_o == SCE_PG_DEF)
    else $error("reboot left a flash page selected");
  a_save_pulse: assert property (save_req |=> !save_req)
    else $error("save request held too long");
  a_user_entry: assert property ($changed(page_o) && page_o == SCE_PG_USER |->
    $past(page_o) == SCE_PG_FLASH) else $error("user page entered from wrong page");
  // Drive must outlast the whole bus clock phase, at least four system cycles
  a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*4])
    else $error("data line drive dropped early");
  a_write_limit: assert property (mem_o.we && page_o != SCE_PG_USER |->
    mem_o.addr <= 8'h8f) else $error("write beyond config limit");
  a_write_owned: assert property (mem_o.we |-> smb_claim)
    else $error("write without bus ownership");
  a_jtag_lock: assert property (jtag_busy [*8] |-> !$rose(smb_claim))
    else $error("bus claimed while jtag owns memory");
  a_fault_pin: assert property ((gp1_alert && !alert_en && fault) [*4] |-> gp1_oe)
    else $error("pin one not following fault");
  a_pin_free: assert property ((!gp1_alert) [*4] |-> !gp1_oe)
    else $error("pin one driven while not alert");
endmodule : sce_engine_assertions

// ==== dv/sce_master_model.sv ====
// Bus master model that clocks bytes over the two-wire link
`timescale 1ns/1ps
module sce_master_model (
  output logic scl,
  output logic m_low,
  input wire logic sda
);
  // Clock stands high between frames; released data is pulled high
  initial begin
    scl = 1'b1;
    m_low = 1'b0;
  end
  // Sample late in the high phase: the slave answers up to 3 cycles after a fall
  task automatic clk_bit(input logic b, output logic s);
    #200 m_low = !b;
    #200 scl = 1'b1;
    #400 s = sda;
    scl = 1'b0;
  endtask : clk_bit
  task automatic start();
    #500 m_low = 1'b0;
    #200 scl = 1'b1;
    #400 m_low = 1'b1;
    #400 scl = 1'b0;
  endtask : start
  task automatic stop();
    #500 m_low = 1'b1;
    #200 scl = 1'b1;
    #400 m_low = 1'b0;
    #400;
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask : wbyte
  // Master acks to continue a read and refuses the final byte
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(!mack, s);
  endtask : rbyte
endmodule : sce_master_model

// ==== dv/sce_engine_tb.sv ====
// Self-checking bench for the two-wire command engine
`timescale 1ns/1ps
module sce_engine_tb
  import sce_pkg::*;
;
  localparam logic [7:0] aw = 8'h54;
  localparam logic [7:0] ar = 8'h55;
  logic mclk, rst_n, scl, m_low, pec_en, alert_en, gp1_alert, fault, dev_busy, jtag_busy;
  logic sda_out, sda_oe, gp1_out, gp1_oe, reboot_req, save_req, alert_status, smb_claim;
  logic ack;
  logic [7:0] b, wa, wd, crc, mem_rdata;
  int n_fail = 0, comparisons = 0, nw = 0, nrb = 0, nsv = 0, k;
  wire logic sda;
  sce_mem_t mem_o;
  sce_page_t page_o;
  logic [7:0] pc [5] = '{8'hab, 8'ha9, 8'hab, 8'hac, 8'haa};
  logic pa [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic [1:0] pp [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0};
  logic [7:0] bad [2] = '{8'h00, 8'h11};
  // Open-drain pad: the line goes low when the master pulls it, or when enabled and the output level is low
  assign sda = !(m_low || (sda_oe && !sda_out));
  // Address-derived pattern so every read is predictable
  assign mem_rdata = mem_o.addr ^ 8'h5a;
  initial begin
    mclk = 1'b0;
    forever #50 mclk = !mclk;
  end
  sce_master_model u_mst (.scl(scl), .m_low(m_low), .sda(sda));
  sce_engine DUT (
    .mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .gp1_out(gp1_out), .gp1_oe(gp1_oe), .slave_addr(7'h2a),
    .pec_en(pec_en), .alert_en(alert_en), .gp1_alert(gp1_alert), .fault(fault),
    .dev_busy(dev_busy), .jtag_busy(jtag_busy), .mem_rdata(mem_rdata), .mem_o(mem_o),
    .page_o(page_o), .reboot_req(reboot_req), .save_req(save_req),
    .alert_status(alert_status), .smb_claim(smb_claim)
  );
  always @(posedge mclk) begin
    if (mem_o.we === 1'b1) begin
      nw++;
      wa = mem_o.addr;
      wd = mem_o.wdata;
    end
    nrb += (reboot_req === 1'b1);
    nsv += (save_req === 1'b1);
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction : crc8
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk1(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask : tick
  task automatic wb(input logic [7:0] d, input logic ea);
    u_mst.wbyte(d, ack);
    crc = crc8(crc, d);
    chk1("ack", ea, ack);
  endtask : wb
  task automatic rb(input logic mack, input logic [7:0] e);
    u_mst.rbyte(mack, b);
    crc = crc8(crc, b);
    chk8("rdata", e, b);
  endtask : rb
  task automatic seq(input logic [7:0] q[$]);
    foreach (q[i]) wb(q[i], 1'b1);
  endtask : seq
  task automatic go(input logic [7:0] a);
    crc = 8'h00;
    u_mst.start();
    wb(a, 1'b1);
  endtask : go
  task automatic cmd(input logic [7:0] c, input logic ea);
    go(aw);
    wb(c, ea);
    u_mst.stop();
    tick(6);
  endtask : cmd
  initial begin
    rst_n = 1'b0;
    {pec_en, alert_en, gp1_alert, fault, dev_busy, jtag_busy} = 6'h00;
    repeat (6) @(posedge mclk);
    #10 rst_n = 1'b1;
    tick(4);
    cmd(8'h10, 1'b1);
    chk8("ptr", 8'h10, mem_o.addr);
    go(ar);
    rb(1'b0, 8'h4a);
    u_mst.stop();
    tick(6);
    chk8("ptr", 8'h11, mem_o.addr);
    go(aw);
    seq('{8'h20, 8'h3c});
    u_mst.stop();
    tick(6);
    chk8("waddr", 8'h20, wa);
    chk8("wdata", 8'h3c, wd);
    cmd(8'h11, 1'b1);
    k = nw;
    cmd(8'h90, 1'b0);
    cmd(8'h94, 1'b0);
    go(aw);
    wb(8'h90, 1'b0);
    wb(8'h77, 1'b0);
    u_mst.stop();
    tick(6);
    chk8("writes", 8'(k), 8'(nw));
    chk8("ptr", 8'h11, mem_o.addr);
    for (int i = 0; i < 5; i++) begin
      cmd(pc[i], pa[i]);
      chk8("page", {6'h00, pp[i]}, {6'h00, page_o});
    end
    cmd(8'ha7, 1'b1);
    cmd(8'ha8, 1'b1);
    chk8("reboots", 8'h01, 8'(nrb));
    chk8("saves", 8'h01, 8'(nsv));
    cmd(8'h8e, 1'b1);
    k = nw;
    go(aw);
    seq('{8'ha5, 8'h03, 8'h11, 8'h22, 8'h33});
    u_mst.stop();
    tick(6);
    chk8("writes", 8'(k + 3), 8'(nw));
    chk8("waddr", 8'h8f, wa);
    chk8("wdata", 8'h33, wd);
    chk8("ptr", 8'h8f, mem_o.addr);
    go(aw);
    for (int i = 0; i < 7; i++) u_mst.clk_bit(1'b0, ack);
    u_mst.stop();
    foreach (bad[i]) begin
      go(aw);
      wb(8'ha5, 1'b1);
      wb(bad[i], 1'b0);
      u_mst.stop();
    end
    dev_busy = 1'b1;
    cmd(8'ha5, 1'b0);
    dev_busy = 1'b0;
    chk8("ptr", 8'h8f, mem_o.addr);
    cmd(8'h40, 1'b1);
    go(aw);
    wb(8'ha6, 1'b1);
    u_mst.start();
    wb(ar, 1'b1);
    rb(1'b1, 8'h10);
    rb(1'b1, 8'h1a);
    rb(1'b0, 8'h1b);
    u_mst.stop();
    jtag_busy = 1'b1;
    u_mst.start();
    wb(aw, 1'b0);
    u_mst.stop();
    jtag_busy = 1'b0;
    {gp1_alert, alert_en} = 2'b11;
    tick(2);
    fault = 1'b1;
    tick(6);
    chk1("alert_pin", 1'b1, gp1_oe);
    chk1("gp1_out", 1'b0, gp1_out);
    fault = 1'b0;
    go(aw);
    seq('{8'h1c, 8'h80});
    u_mst.stop();
    tick(6);
    chk1("alert_status", 1'b1, alert_status);
    go(8'h13);
    rb(1'b0, aw);
    u_mst.stop();
    tick(6);
    chk1("alert_pin", 1'b0, gp1_oe);
    u_mst.start();
    wb(8'h13, 1'b0);
    u_mst.stop();
    tick(6);
    chk1("alert_status", 1'b1, alert_status);
    go(aw);
    seq('{8'h1c, 8'h80});
    u_mst.stop();
    tick(6);
    chk1("alert_status", 1'b0, alert_status);
    alert_en = 1'b0;
    fault = 1'b1;
    tick(6);
    chk1("alert_pin", 1'b1, gp1_oe);
    fault = 1'b0;
    pec_en = 1'b1;
    for (int i = 0; i < 2; i++) begin
      go(aw);
      seq('{8'h20, 8'h3c});
      wb(crc ^ 8'(i), 1'(1 - i));
      u_mst.stop();
    end
    go(aw);
    wb(8'h30, 1'b1);
    u_mst.start();
    wb(ar, 1'b1);
    rb(1'b1, 8'h6a);
    rb(1'b0, crc);
    u_mst.stop();
    tick(6);
    go(aw);
    seq('{8'ha5, 8'h01, 8'h44});
    wb(crc, 1'b1);
    u_mst.stop();
    tick(6);
    chk8("waddr", 8'h31, wa);
    chk8("wdata", 8'h44, wd);
    complete_run();
  end
  initial begin
    #3000000;
    n_fail++;
    complete_run();
  end
endmodule : sce_engine_tb
bind sce_engine sce_engine_assertions u_chk (
  .mclk(mclk), .rst_n(rst_n), .alert_en(alert_en), .gp1_alert(gp1_alert), .fault(fault),
  .jtag_busy(jtag_busy), .sda_oe(sda_oe), .gp1_oe(gp1_oe), .mem_o(mem_o), .page_o(page_o),
  .reboot_req(reboot_req), .save_req(save_req), .smb_claim(smb_claim)
);
